// ---- core/dtp_top.sv ----
// Dual 8-bit timer/counter pair with prescalers behind an AHB-Lite slave
// Assumes one system clock at 40 MHz and a single AHB-Lite master
//
// Behaviour
// - Shared prescaler is a 10-bit divider with taps /8, /64, /256, /1024.
// - Timer A may also run undivided, from the external pin, or stop.
// - Shared prescaler reset bit restarts the divider and always reads zero.
// - Timer B prescaler reset self-clears; in async mode reads one until done.
// - Timer B source is the system clock, or the oscillator pin in async mode.
// - Async mode detaches both oscillator pins from their port function.
// - Upper six bits of the special function register read zero.
// - External count pin is sampled on clk; edges at least a period apart.
// - Overflow and match flags share one register; enables share another.
// - Force applies the pin action now; no flag, no clear, not in PWM.
// - Mode written with force takes effect from the next match.
// - PWM enable bit selects PWM operation, else normal counting.
// - Outside PWM, modes 00 off, 01 toggle, 10 low, 11 high.
// - Compare pin drives only while its direction bit selects output.
// - Outside PWM, clear-on-match returns counter to zero the cycle after a match.
// - Without clear-on-match the counter runs on past a match.
// - In PWM, clear-on-match off counts up/down; on wraps after 0xFF.
// - Timer A codes: stop, clk, /8, /64, /256, /1024, pin fall, pin rise.
// - Timer B codes: stop, then source /1, /8, /32, /64, /128, /256, /1024.
// - PWM modes: 0x off; 10/11 set or clear by match and overflow, or by up and down matches.
// - In PWM, compare writes are held and copied in at counter 0xFF.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "dtp_consts.svh"
module dtp_top
(
   input wire logic clk, // System clock
   input wire logic rstn, // Reset, active low
   input wire logic hsel, // AHB slave select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write
   input wire logic [2:0] hsize, // AHB size, word only
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB bus ready
   output logic hreadyout, // AHB slave ready
   output logic [31:0] hrdata, // AHB read data
   output logic hresp, // AHB response, always OKAY
   input wire logic oscPinIn, // Oscillator pin, async source
   input wire logic extCountPin, // External count pin of timer A
   output logic cmpPinA, // Compare output of timer A
   output logic cmpPinAOe, // Drive enable of timer A pin
   output logic cmpPinB, // Compare output of timer B
   output logic cmpPinBOe, // Drive enable of timer B pin
   output logic oscPinsDetach // Both oscillator pins leave the port
);
   import dtp_pkg::*;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rstSync_ff;
   logic rstSn;

   // Assert at once, release two edges later
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rstSync_ff <= 2'h0;
      else
         rstSync_ff <= {rstSync_ff[0], 1'b1};
   end
   assign rstSn = rstSync_ff[1];

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   dtp_top_s st_ff;
   dtp_top_s nxt_st;
   dtp_tmr_if tA();
   dtp_tmr_if tB();
   logic [`DTP_PSC_W-1:0] pscATap;
   logic [`DTP_PSC_W-1:0] pscBTap;
   logic inRange;
   logic [7:0] aIdx;
   logic [7:0] rdVal;
   logic wrEn;
   logic [7:0] wd;
   logic pscAClr;
   logic pscBClr;
   logic asyRstWr;
   logic timerBPrescSrc;
   logic extRise;
   logic extFall;
   logic tickA;
   logic tickB;
   logic [2:0] csA;
   logic [2:0] csB;
   logic pwmA;
   logic ctcA;
   logic connA;
   logic connB;
   logic [3:0] flagSet;
   logic [3:0] flagClr;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Out-of-range addresses fold onto an unused index and read zero
   assign inRange = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
   assign aIdx = inRange ? haddr[9:2] : 8'h00;
   assign wrEn = (st_ff.bus == DTP_BS_WR);
   assign wd = hwdata[7:0];
   assign asyRstWr = wrEn && st_ff.idx == `DTP_IDX_SFR && wd[`DTP_B_ASY_RST];
   assign flagClr = (wrEn && st_ff.idx == `DTP_IDX_FLAG) ? wd[3:0] : 4'h0;

   // Read data is taken in the address phase, so reads add no wait state
   always_comb
   begin
      case (aIdx)
         `DTP_IDX_CTRL_A: rdVal = st_ff.ctrlA;
         `DTP_IDX_CTRL_B: rdVal = st_ff.ctrlB;
         `DTP_IDX_SFR: rdVal = {6'h00, st_ff.pendB, 1'b0};
         `DTP_IDX_CNT_A: rdVal = tA.cnt;
         `DTP_IDX_CNT_B: rdVal = tB.cnt;
         `DTP_IDX_CMP_A: rdVal = tA.cmp;
         `DTP_IDX_CMP_B: rdVal = tB.cmp;
         `DTP_IDX_FLAG: rdVal = {4'h0, st_ff.flags};
         `DTP_IDX_MASK: rdVal = {4'h0, st_ff.mask};
         `DTP_IDX_ASYNC: rdVal = {7'h00, st_ff.asyncSel};
         `DTP_IDX_DIR: rdVal = {6'h00, st_ff.dir};
         default: rdVal = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Prescalers and clock selection
   // ----------------------------------------------------------------
   // shared reset restarts only the divider that feeds timer A
   assign pscAClr = wrEn && st_ff.idx == `DTP_IDX_SFR && wd[`DTP_B_SHR_RST];

   // timer B source, rising oscillator edges in async mode
   // a slow oscillator keeps every edge visible after the sync
   assign timerBPrescSrc = st_ff.asyncSel ? (st_ff.oscSync[1] && !st_ff.oscSync[2]) : 1'b1;

   // sync mode resets at once, async at the next source edge
   assign pscBClr = (asyRstWr && !st_ff.asyncSel) || (st_ff.pendB && timerBPrescSrc);

   // shared ten-bit divider of the system clock
   dtp_prescaler #(.W(`DTP_PSC_W)) uPscA (
      .clk(clk),
      .rstSn(rstSn),
      .clr(pscAClr),
      .en(1'b1),
      .tap(pscATap)
   );

   dtp_prescaler #(.W(`DTP_PSC_W)) uPscB (
      .clk(clk),
      .rstSn(rstSn),
      .clr(pscBClr),
      .en(timerBPrescSrc),
      .tap(pscBTap)
   );

   // pin edges taken from the synchronised copy only
   assign extRise = st_ff.extSync[1] && !st_ff.extSync[2];
   assign extFall = !st_ff.extSync[1] && st_ff.extSync[2];
   assign csA = st_ff.ctrlA[2:0];
   assign csB = st_ff.ctrlB[2:0];

   always_comb
   begin
      case (csA)
         `DTP_CS_STOP: tickA = 1'b0;
         `DTP_CS_DIV1: tickA = 1'b1;
         3'h2: tickA = pscATap[`DTP_TAP_8];
         3'h3: tickA = pscATap[`DTP_TAP_64];
         3'h4: tickA = pscATap[`DTP_TAP_256];
         3'h5: tickA = pscATap[`DTP_TAP_1024];
         `DTP_CS_EXTF: tickA = extFall;
         `DTP_CS_EXTR: tickA = extRise;
         default: tickA = 1'b0;
      endcase
   end

   always_comb
   begin
      case (csB)
         `DTP_CS_STOP: tickB = 1'b0;
         `DTP_CS_DIV1: tickB = timerBPrescSrc;
         3'h2: tickB = pscBTap[`DTP_TAP_8];
         3'h3: tickB = pscBTap[`DTP_TAP_32];
         3'h4: tickB = pscBTap[`DTP_TAP_64];
         3'h5: tickB = pscBTap[`DTP_TAP_128];
         3'h6: tickB = pscBTap[`DTP_TAP_256];
         3'h7: tickB = pscBTap[`DTP_TAP_1024];
         default: tickB = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Timer units
   // ----------------------------------------------------------------
   // PWM and clear-on-match bits steer the units
   assign tA.cfg = st_ff.ctrlA;
   assign tB.cfg = st_ff.ctrlB;
   assign tA.tick = tickA;
   assign tB.tick = tickB;
   assign tA.wdata = wd;
   assign tB.wdata = wd;
   assign tA.cntWr = wrEn && st_ff.idx == `DTP_IDX_CNT_A;
   assign tB.cntWr = wrEn && st_ff.idx == `DTP_IDX_CNT_B;
   assign tA.cmpWr = wrEn && st_ff.idx == `DTP_IDX_CMP_A;
   assign tB.cmpWr = wrEn && st_ff.idx == `DTP_IDX_CMP_B;
   // force sees the mode still held, new mode lands this edge
   assign tA.forceCmp = wrEn && st_ff.idx == `DTP_IDX_CTRL_A && wd[`DTP_B_FORCE];
   assign tB.forceCmp = wrEn && st_ff.idx == `DTP_IDX_CTRL_B && wd[`DTP_B_FORCE];

   dtp_timer uTimerA (
      .clk(clk),
      .rstSn(rstSn),
      .tif(tA.unit)
   );

   dtp_timer uTimerB (
      .clk(clk),
      .rstSn(rstSn),
      .tif(tB.unit)
   );

   assign pwmA = st_ff.ctrlA[`DTP_B_PWM];
   assign ctcA = st_ff.ctrlA[`DTP_B_CTC];
   // PWM modes 0x are off; normal mode only 00 is off
   assign connA = pwmA ? st_ff.ctrlA[`DTP_B_COMH] : (st_ff.ctrlA[5:4] != 2'h0);
   assign connB = st_ff.ctrlB[`DTP_B_PWM] ? st_ff.ctrlB[`DTP_B_COMH]
      : (st_ff.ctrlB[5:4] != 2'h0);
   assign flagSet = {tB.matchEv, tB.ovfEv, tA.matchEv, tA.ovfEv};

   // ----------------------------------------------------------------
   // Register file and bus state
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rdy = 1'b1;
      nxt_st.resp = 1'b0;
      nxt_st.oscSync = {st_ff.oscSync[1:0], oscPinIn};
      nxt_st.extSync = {st_ff.extSync[1:0], extCountPin};
      nxt_st.bus = DTP_BS_IDLE;
      if (hsel && htrans[1] && hready)
      begin
         nxt_st.bus = hwrite ? DTP_BS_WR : DTP_BS_RD;
         nxt_st.idx = aIdx;
         nxt_st.rd = rdVal;
      end
      if (wrEn)
      begin
         case (st_ff.idx)
            `DTP_IDX_CTRL_A: nxt_st.ctrlA = wd & `DTP_CTRL_WMASK;
            `DTP_IDX_CTRL_B: nxt_st.ctrlB = wd & `DTP_CTRL_WMASK;
            `DTP_IDX_MASK: nxt_st.mask = wd[3:0];
            `DTP_IDX_ASYNC: nxt_st.asyncSel = wd[0];
            `DTP_IDX_DIR: nxt_st.dir = wd[1:0];
            default: nxt_st.dir = st_ff.dir;
         endcase
      end
      // shared flags, a new event wins over a clear
      nxt_st.flags = (st_ff.flags & ~flagClr) | flagSet;
      // pending request ends on the oscillator edge
      if (!st_ff.asyncSel)
         nxt_st.pendB = 1'b0;
      else if (asyRstWr)
         nxt_st.pendB = 1'b1;
      else if (st_ff.pendB && timerBPrescSrc)
         nxt_st.pendB = 1'b0;
      // oscillator pins leave the port in async mode
      nxt_st.detach = st_ff.asyncSel;
      // pin driven only with direction set to output
      nxt_st.pinA = tA.pin;
      nxt_st.oeA = st_ff.dir[0] && connA;
      nxt_st.pinB = tB.pin;
      nxt_st.oeB = st_ff.dir[1] && connB;
   end

   always_ff @(posedge clk or negedge rstSn)
   begin
      if (!rstSn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   // Every output straight from the state register
   assign hreadyout = st_ff.rdy;
   assign hresp = st_ff.resp;
   assign hrdata = {24'h00_0000, st_ff.rd};
   assign cmpPinA = st_ff.pinA;
   assign cmpPinAOe = st_ff.oeA;
   assign cmpPinB = st_ff.pinB;
   assign cmpPinBOe = st_ff.oeB;
   assign oscPinsDetach = st_ff.detach;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstSn);

   sequence sfrReadAddr;
      hsel && htrans[1] && hready && !hwrite && aIdx == `DTP_IDX_SFR;
   endsequence

   sequence asyRstReq;
      asyRstWr && st_ff.asyncSel;
   endsequence

   sequence oscQuiet;
      st_ff.asyncSel && !timerBPrescSrc;
   endsequence

   a_sfr_reserved:
   assert property (sfrReadAddr |=> hrdata[7:2] == 6'h00)
      else $error("Reserved special function bits read non-zero");

   a_shrst_reads_zero:
   assert property (sfrReadAddr |=> !hrdata[`DTP_B_SHR_RST])
      else $error("Shared prescaler reset bit read as one");

   a_shrst_restart:
   assert property (pscAClr |=> !pscATap[`DTP_TAP_8] [*7] ##1 pscATap[`DTP_TAP_8])
      else $error("Divide-by-8 tap wrong after shared reset");

   a_asyrst_sync_zero:
   assert property (asyRstWr && !st_ff.asyncSel |=> !st_ff.pendB)
      else $error("Timer B reset bit stuck in sync mode");

   a_asyrst_hold:
   assert property (asyRstReq ##1 oscQuiet [*2] |-> st_ff.pendB)
      else $error("Async reset bit cleared before the oscillator edge");

   a_asyrst_done:
   assert property (st_ff.pendB && timerBPrescSrc && !asyRstWr |=> !st_ff.pendB)
      else $error("Async reset bit not cleared after the oscillator edge");

   a_osc_detach:
   assert property ($rose(st_ff.asyncSel) |=> oscPinsDetach)
      else $error("Oscillator pins not detached in async mode");

   a_oe_needs_dir:
   assert property (!st_ff.dir[0] |=> !cmpPinAOe)
      else $error("Compare pin A driven with direction input");

   a_ctc_clear:
   assert property (tA.matchEv && ctcA && !pwmA && !tA.cntWr |=> tA.cnt == `DTP_CNT_BOT)
      else $error("Counter A not cleared after match");

   a_force_no_irq:
   assert property (tA.forceCmp && !tA.matchEv |=> !$rose(st_ff.flags[`DTP_F_CMP_A]))
      else $error("Forced compare raised the match flag");

   a_force_no_clear:
   assert property (tA.forceCmp && ctcA && !pwmA && !tA.tick && !tA.matchEv
      && !tA.cntWr |=> $stable(tA.cnt))
      else $error("Forced compare changed counter A");

   a_ext_rise:
   assert property ($rose(st_ff.extSync[1]) && csA == `DTP_CS_EXTR |-> tA.tick)
      else $error("Rising pin edge did not count timer A");

   a_pwm_turn:
   assert property (pwmA && !ctcA && tA.tick && !tA.cntWr && tA.cnt == `DTP_CNT_TOP
      |=> tA.cnt == `DTP_CNT_TOP - 8'h01)
      else $error("Up/down counter A did not turn at top");
endmodule

// ---- core/dtp_consts.svh ----
// Register indices, field positions, select codes and taps of the timer pair
// Definitions only; included by every design module
`ifndef DTP_CONSTS_SVH
`define DTP_CONSTS_SVH
// Register indices; byte address is four times the index
`define DTP_IDX_CMP_B 8'h22
`define DTP_IDX_CNT_B 8'h23
`define DTP_IDX_ASYNC 8'h26
`define DTP_IDX_CTRL_B 8'h27
`define DTP_IDX_SFR 8'h30
`define DTP_IDX_CMP_A 8'h31
`define DTP_IDX_CNT_A 8'h32
`define DTP_IDX_CTRL_A 8'h33
`define DTP_IDX_FLAG 8'h38
`define DTP_IDX_MASK 8'h39
`define DTP_IDX_DIR 8'h3A
// Control register fields
`define DTP_B_FORCE 7
`define DTP_B_PWM 6
`define DTP_B_COMH 5
`define DTP_B_COML 4
`define DTP_B_CTC 3
`define DTP_CTRL_WMASK 8'h7F
// Special function register fields
`define DTP_B_SHR_RST 0
`define DTP_B_ASY_RST 1
// Flag register fields
`define DTP_F_CMP_A 1
// Clock select codes
`define DTP_CS_STOP 3'h0
`define DTP_CS_DIV1 3'h1
`define DTP_CS_EXTF 3'h6
`define DTP_CS_EXTR 3'h7
// Prescaler width and taps, tap k divides by 2**(k+1)
`define DTP_PSC_W 10
`define DTP_TAP_8 2
`define DTP_TAP_32 4
`define DTP_TAP_64 5
`define DTP_TAP_128 6
`define DTP_TAP_256 7
`define DTP_TAP_1024 9
// Counter limits
`define DTP_CNT_TOP 8'hFF
`define DTP_CNT_BOT 8'h00
`endif

// ---- core/dtp_pkg.sv ----
// Types of the dual 8-bit timer block
// Used by every design module; holds no logic
package dtp_pkg;
   // Bus phase, Gray along idle to either data phase
   typedef enum logic [1:0] {DTP_BS_IDLE = 2'h0, DTP_BS_WR = 2'h1, DTP_BS_RD = 2'h2} dtp_bus_e;
   // State of one timer unit
   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] cmpAct;
      logic [7:0] cmpHold;
      logic down;
      logic counted;
      logic pin;
   } dtp_tmr_s;
   // State of the top level
   typedef struct packed {
      dtp_bus_e bus;
      logic [7:0] idx;
      logic [7:0] rd;
      logic rdy;
      logic resp;
      logic [7:0] ctrlA;
      logic [7:0] ctrlB;
      logic [3:0] flags;
      logic [3:0] mask;
      logic [1:0] dir;
      logic asyncSel;
      logic pendB;
      logic detach;
      logic pinA;
      logic oeA;
      logic pinB;
      logic oeB;
      logic [2:0] oscSync;
      logic [2:0] extSync;
   } dtp_top_s;
endpackage

// ---- core/dtp_tmr_if.sv ----
// Link between the register file and one timer unit
// Both ends run on the system clock
`timescale 1ns/1ps
interface dtp_tmr_if;
   logic tick;
   logic cntWr;
   logic cmpWr;
   logic forceCmp;
   logic [7:0] cfg;
   logic [7:0] wdata;
   logic [7:0] cnt;
   logic [7:0] cmp;
   logic matchEv;
   logic ovfEv;
   logic pin;
   modport ctl (output tick, cntWr, cmpWr, forceCmp, cfg, wdata,
      input cnt, cmp, matchEv, ovfEv, pin);
   modport unit (input tick, cntWr, cmpWr, forceCmp, cfg, wdata,
      output cnt, cmp, matchEv, ovfEv, pin);
endinterface

// ---- core/dtp_prescaler.sv ----
// Free-running binary prescaler with one tick output per bit
// Assumes en is a one-cycle source edge on the system clock
`timescale 1ns/1ps
`include "dtp_consts.svh"
module dtp_prescaler
#(
   parameter int W = `DTP_PSC_W // Divider width
)
(
   input wire logic clk, // System clock
   input wire logic rstSn, // Synchronised reset, active low
   input wire logic clr, // Restart from zero
   input wire logic en, // Source edge, one cycle
   output logic [W-1:0] tap // Tick every 2**(k+1) source edges
);
   import dtp_pkg::*;
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;

   // Taps up to divide-by-1024 need ten bits
   if (W < `DTP_PSC_W)
   begin : g_chk
      $error("Prescaler narrower than ten bits");
   end

   // One tap per bit, suppressed while restarting
   for (genvar k = 0; k < W; k++)
   begin : g_tap
      assign tap[k] = en && !clr && (&cnt_ff[k:0]);
   end

   // Clear wins over counting
   always_comb
   begin
      nxt_cnt = clr ? '0 : (en ? cnt_ff + 1'b1 : cnt_ff);
   end

   always_ff @(posedge clk or negedge rstSn)
   begin
      if (!rstSn)
         cnt_ff <= '0;
      else
         cnt_ff <= nxt_cnt;
   end
endmodule

// ---- core/dtp_timer.sv ----
// One 8-bit timer/counter: counter, compare, PWM and compare pin action
// Assumes tick, writes and force are one-cycle pulses on the system clock
`timescale 1ns/1ps
`include "dtp_consts.svh"
module dtp_timer
(
   input wire logic clk, // System clock
   input wire logic rstSn, // Synchronised reset, active low
   dtp_tmr_if.unit tif // Register file side
);
   import dtp_pkg::*;
   dtp_tmr_s st_ff;
   dtp_tmr_s nxt_st;
   logic pwm;
   logic ctc;
   logic act;
   logic [1:0] mode;

   assign tif.cnt = st_ff.cnt;
   assign tif.cmp = st_ff.cmpHold;
   assign tif.pin = st_ff.pin;

   // Counter, compare and pin; a software write never makes a match
   always_comb
   begin
      pwm = tif.cfg[`DTP_B_PWM];
      ctc = tif.cfg[`DTP_B_CTC];
      mode = tif.cfg[`DTP_B_COMH:`DTP_B_COML];
      nxt_st = st_ff;
      nxt_st.counted = 1'b0;
      tif.matchEv = st_ff.counted && (st_ff.cnt == st_ff.cmpAct);
      tif.ovfEv = 1'b0;
      act = tif.matchEv || (tif.forceCmp && !pwm);
      if (tif.cntWr)
         nxt_st.cnt = tif.wdata;
      else if (tif.matchEv && ctc && !pwm)
         nxt_st.cnt = `DTP_CNT_BOT;
      else if (tif.tick)
      begin
         nxt_st.counted = 1'b1;
         // turn at the ends in up/down mode
         if (pwm && !ctc && (st_ff.down ? st_ff.cnt == `DTP_CNT_BOT
            : st_ff.cnt == `DTP_CNT_TOP))
            nxt_st.down = !st_ff.down;
         nxt_st.cnt = nxt_st.down ? st_ff.cnt - 8'h01 : st_ff.cnt + 8'h01;
         // plain wrap ignores the compare value
         tif.ovfEv = (pwm && !ctc) ? (st_ff.down && st_ff.cnt == `DTP_CNT_BOT)
            : (st_ff.cnt == `DTP_CNT_TOP);
      end
      if (!pwm || ctc)
         nxt_st.down = 1'b0;
      // buffered compare value taken at top
      if (pwm && st_ff.counted && st_ff.cnt == `DTP_CNT_TOP)
         nxt_st.cmpAct = st_ff.cmpHold;
      if (tif.cmpWr)
      begin
         nxt_st.cmpHold = tif.wdata;
         if (!pwm)
            nxt_st.cmpAct = tif.wdata;
      end
      // PWM pin actions by match and overflow
      if (pwm)
      begin
         if (tif.matchEv && mode[1])
            nxt_st.pin = ctc ? mode[0] : (st_ff.down ^ mode[0]);
         else if (tif.ovfEv && ctc && mode[1])
            nxt_st.pin = !mode[0];
      end
      // normal mode pin actions, old mode on force
      else if (act)
      begin
         case (mode)
            2'h1: nxt_st.pin = !st_ff.pin;
            2'h2: nxt_st.pin = 1'b0;
            2'h3: nxt_st.pin = 1'b1;
            default: nxt_st.pin = st_ff.pin;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstSn)
   begin
      if (!rstSn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end
endmodule

// ---- tb/dtp_tb.sv ----
// Self-checking bench of the dual 8-bit timer block, driven over AHB-Lite
// Assumes core/ is compiled first and hready is the slave's own hreadyout
`timescale 1ns/1ps
`include "dtp_consts.svh"
`define CHK(what, exp, got) \
   begin \
      compares++; \
      if ((got) !== (exp)) \
      begin \
         n_fail++; \
         $display("[FAIL] %s expected %h seen %h", what, exp, got); \
      end \
   end
module tb;
   logic clk = 1'b0;
   logic rstn, hsel, hwrite, hreadyout, hresp, oscPinIn, extCountPin;
   logic cmpPinA, cmpPinAOe, cmpPinB, cmpPinBOe, oscPinsDetach;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] v;
   logic [7:0] fm [4] = '{8'h30, 8'h20, 8'h10, 8'h10};
   logic fe [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;
   int i;
   // Half period of 12.5 ns gives 40 MHz
   always #12.5 clk = ~clk;
   dtp_top dtp_top_inst (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .oscPinIn(oscPinIn),
      .extCountPin(extCountPin), .cmpPinA(cmpPinA), .cmpPinAOe(cmpPinAOe),
      .cmpPinB(cmpPinB), .cmpPinBOe(cmpPinBOe), .oscPinsDetach(oscPinsDetach));
   //----------------------------------------
   // Bus tasks and verdict
   //----------------------------------------
   task automatic give_verdict();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // One single transfer; waits on hready in both phases, no fixed latency
   task automatic busCycle(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
      output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1)
         @(posedge clk);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      @(posedge clk);
      while (hreadyout !== 1'b1)
         @(posedge clk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] x;
      busCycle(1'b1, idx, d, x);
   endtask
   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      logic [31:0] x;
      busCycle(1'b0, idx, 8'h00, x);
      d = x[7:0];
   endtask
   task automatic rdChk(input string what, input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] x;
      busCycle(1'b0, idx, 8'h00, x);
      `CHK(what, exp, x)
   endtask
   // Pins move a cycle after the register; leave margin before looking
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   // Hang guard, far above the several hundred cycles the tests need
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         give_verdict();
      end
   end
   //----------------------------------------
   // Tests
   //----------------------------------------
   initial
   begin
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      oscPinIn = 1'b0;
      extCountPin = 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (5) @(posedge clk);
      rdChk("ctrlA reset", `DTP_IDX_CTRL_A, 32'h0000_0000);
      rdChk("ctrlB reset", `DTP_IDX_CTRL_B, 32'h0000_0000);
      rdChk("sfr reset", `DTP_IDX_SFR, 32'h0000_0000);
      wr(8'h01, 8'hFF);
      rdChk("unmapped", 8'h01, 32'h0000_0000);
      wr(`DTP_IDX_SFR, 8'hFF);
      rdChk("sfr reads zero", `DTP_IDX_SFR, 32'h0000_0000);
      wr(`DTP_IDX_CTRL_A, 8'h8F);
      rdChk("force reads zero", `DTP_IDX_CTRL_A, 32'h0000_000F);
      `CHK("okay response", 1'b0, hresp)
      $display("test registers done");
      // Clear on match at divide by 1, then free running past the match
      wr(`DTP_IDX_CTRL_A, 8'h00);
      wr(`DTP_IDX_CMP_A, 8'h05);
      wr(`DTP_IDX_CNT_A, 8'h00);
      wr(`DTP_IDX_FLAG, 8'h0F);
      wr(`DTP_IDX_CTRL_A, 8'h09);
      for (i = 0; i < 8; i++)
      begin
         rd(`DTP_IDX_CNT_A, v);
         `CHK("count within match", 1'b1, v <= 8'h05)
      end
      rdChk("match flag", `DTP_IDX_FLAG, 32'h0000_0002);
      wr(`DTP_IDX_CTRL_A, 8'h01);
      wr(`DTP_IDX_CNT_A, 8'h00);
      repeat (12) @(posedge clk);
      rd(`DTP_IDX_CNT_A, v);
      `CHK("count past match", 1'b1, v > 8'h05)
      wr(`DTP_IDX_CTRL_A, 8'h00);
      wr(`DTP_IDX_FLAG, 8'h0F);
      rdChk("flags cleared", `DTP_IDX_FLAG, 32'h0000_0000);
      $display("test clear on match done");
      // External pin, falling then rising edge codes, edges 4 cycles apart
      for (i = 0; i < 2; i++)
      begin
         wr(`DTP_IDX_CTRL_A, 8'h00);
         wr(`DTP_IDX_CNT_A, 8'h00);
         wr(`DTP_IDX_CTRL_A, {7'h03, i[0]});
         repeat (6)
         begin
            repeat (4) @(posedge clk);
            extCountPin <= ~extCountPin;
         end
         repeat (6) @(posedge clk);
         rd(`DTP_IDX_CNT_A, v);
         `CHK("external edges", 8'h03, v)
      end
      $display("test external count done");
      // Forced compare in modes 11, 10 and 01; mode set first, then force alone
      wr(`DTP_IDX_CTRL_A, 8'h00);
      wr(`DTP_IDX_FLAG, 8'h0F);
      wr(`DTP_IDX_DIR, 8'h01);
      for (i = 0; i < 4; i++)
      begin
         wr(`DTP_IDX_CTRL_A, fm[i]);
         wr(`DTP_IDX_CTRL_A, fm[i] | 8'h80);
         settle();
         `CHK("forced pin", fe[i], cmpPinA)
      end
      `CHK("pin driven", 1'b1, cmpPinAOe)
      wr(`DTP_IDX_CTRL_A, 8'hA0);
      settle();
      `CHK("new mode waits", 1'b1, cmpPinA)
      rdChk("force sets no flag", `DTP_IDX_FLAG, 32'h0000_0000);
      wr(`DTP_IDX_CTRL_A, 8'h60);
      wr(`DTP_IDX_CTRL_A, 8'hE0);
      settle();
      `CHK("force idle in pwm", 1'b1, cmpPinA)
      wr(`DTP_IDX_DIR, 8'h00);
      settle();
      `CHK("pin released", 1'b0, cmpPinAOe)
      // Divide-by-8 tap: 80 clocks give ten counts, phase unknown
      wr(`DTP_IDX_CTRL_A, 8'h00);
      wr(`DTP_IDX_CNT_A, 8'h00);
      wr(`DTP_IDX_CTRL_A, 8'h02);
      repeat (78) @(posedge clk);
      rd(`DTP_IDX_CNT_A, v);
      `CHK("divide by 8", 1'b1, v >= 8'h09 && v <= 8'h0B)
      // Up/down count turns at the top instead of wrapping to zero
      wr(`DTP_IDX_CTRL_A, 8'h00);
      wr(`DTP_IDX_CNT_A, 8'hF8);
      wr(`DTP_IDX_CTRL_A, 8'h41);
      repeat (15) @(posedge clk);
      rd(`DTP_IDX_CNT_A, v);
      `CHK("up/down turn", 1'b1, v >= 8'hF0 && v < 8'hFF)
      $display("test force compare done");
      // Async select detaches the oscillator pins
      wr(`DTP_IDX_ASYNC, 8'h01);
      settle();
      `CHK("pins detached", 1'b1, oscPinsDetach)
      // Async reset request holds until an oscillator rise
      wr(`DTP_IDX_CNT_B, 8'h00);
      wr(`DTP_IDX_CTRL_B, 8'h01);
      wr(`DTP_IDX_SFR, 8'h02);
      rdChk("async reset pending", `DTP_IDX_SFR, 32'h0000_0002);
      // Half period of 80 clocks keeps the oscillator below 256 kHz
      repeat (4)
      begin
         repeat (80) @(posedge clk);
         oscPinIn <= ~oscPinIn;
      end
      repeat (6) @(posedge clk);
      rdChk("async reset done", `DTP_IDX_SFR, 32'h0000_0000);
      rdChk("async count", `DTP_IDX_CNT_B, 32'h0000_0002);
      // Timer B pin: set mode first, then force alone
      wr(`DTP_IDX_DIR, 8'h02);
      wr(`DTP_IDX_CTRL_B, 8'h31);
      wr(`DTP_IDX_CTRL_B, 8'hB1);
      settle();
      `CHK("forced pin b", 1'b1, cmpPinB)
      `CHK("pin b driven", 1'b1, cmpPinBOe)
      wr(`DTP_IDX_ASYNC, 8'h00);
      settle();
      `CHK("pins attached", 1'b0, oscPinsDetach)
      $display("test async select done");
      give_verdict();
   end
endmodule
